// ---- verilog/dspclk_pkg.sv ----
// Constants, register map and types for the signal-processor clock generator.
// Assumes a single 100 MHz core clock; all slower rates are enable pulses.
package dspclk_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 16;
  localparam logic [3:0]  CMR_OFF        = 4'h0;  // clock mode control register
  localparam logic [3:0]  BANK_SWITCH_CONTROL_REGISTER_OFF       = 4'h1;  // bank switch control register
  localparam logic [3:0]  STAT_OFF       = 4'h2;  // clock status register

  // Clock mode control register fields
  localparam int          MULT_FRAC_LSB  = 0;     // quarter steps of the factor
  localparam int          MULT_INT_LSB   = 2;     // integer part of the factor
  localparam int          PLL_EN_BIT     = 6;
  localparam logic [5:0]  MULT_RESET     = 6'h04; // factor 1.0 in quarters

  // Bank switch control register: output clock divide field
  localparam int          OUTPUT_CLOCK_DIVIDE_FIELD_LSB     = 0;
  localparam logic [1:0]  OUTPUT_CLOCK_DIVIDE_FIELD_NONE    = 2'h0;
  localparam logic [1:0]  OUTPUT_CLOCK_DIVIDE_FIELD_BY4     = 2'h3;
  localparam logic [1:0]  OUTPUT_CLOCK_DIVIDE_FIELD_RESET   = OUTPUT_CLOCK_DIVIDE_FIELD_BY4;

  // Status register fields
  localparam int          ST_LOCK_BIT    = 0;
  localparam int          ST_PLL_BIT     = 1;
  localparam int          ST_OSC_BIT     = 2;
  localparam int          ST_RANGE_BIT   = 3;
  localparam int          ST_STRAP_LSB   = 4;

  // Mode pin patterns {pin_a, pin_b, pin_c}
  localparam logic [2:0]  STRAP_DIV2_LO  = 3'h0;
  localparam logic [2:0]  STRAP_DIV4     = 3'h5;
  localparam logic [2:0]  STRAP_DIV2_HI  = 3'h7;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          LOCK_TIME_NS   = 30000;
  localparam int          LOCK_CYCLES    = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int          REF_MIN_NS     = 20;
  localparam int          REF_MAX_INT_NS = 200;
  localparam int          REF_MAX_H_NS   = 100;
  localparam int          REF_MAX_Q_NS   = 50;
  localparam int          REF_MIN_CYC    = (REF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REF_MAX_INT_CYC = REF_MAX_INT_NS / CLK_PERIOD_NS;
  localparam int          REF_MAX_H_CYC  = REF_MAX_H_NS / CLK_PERIOD_NS;
  localparam int          REF_MAX_Q_CYC  = REF_MAX_Q_NS / CLK_PERIOD_NS;
  localparam int          PERIOD_W       = 16;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DSPCLK_MODE_DIV2,
    DSPCLK_MODE_DIV4,
    DSPCLK_MODE_PLL
  } dspclk_mode_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dspclk_bus_s;

endpackage

// ---- verilog/dspclk_out_div.sv ----
// Output clock pin divider: turns machine half-period pulses into the pin level.
// Assumes half_tick_i is a one-cycle pulse at twice the machine clock rate.
`timescale 1ns/1ps
`default_nettype none
module dspclk_out_div
  import dspclk_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // Control
  input  wire logic       half_tick_i,
  input  wire logic [1:0] output_clock_divide_field_i,
  // Pin
  output logic            clk_out_o
);
  import dspclk_pkg::*;

  // ==========================================================================
  // Divide ratio decode: field value n gives a divide by n+1
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       wrap;

  assign wrap     = (cnt_reg >= output_clock_divide_field_i);
  assign cnt_next = wrap ? 2'h0 : cnt_reg + 2'h1;

  // Toggle the pin every output_clock_divide_field+1 half periods; field 00 follows the machine clock
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cnt_reg   <= 2'h0;
      clk_out_o <= 1'b0;
    end else if (half_tick_i) begin
      cnt_reg <= cnt_next;
      if (wrap) begin
        clk_out_o <= ~clk_out_o;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/dspclk_top.sv ----
// Clock generator core: mode pins, divide-by-2/4, fractional PLL model, output pin.
// Assumes pins synchronous to core_clk_i; reference edges are sampled, not clocked.
//
// Notes on behaviour
// - Mode pins sampled in reset; 000/111 divide by 2, 101 by 4, PLL off.
// - Machine clock is half, quarter, or control-register multiple of reference.
// - Oscillator enabled only by a mode pattern that asks for it.
// - Output divide field resets to divide-by-4.
// - Divide field 00 drives the output pin at machine rate.
// - Integer factors 1 through 15, reference period 20 to 200 ns.
// - Fractional .5/.25/.75 factors; tighter reference period limits flagged.
// - PLL locks within 30 us of a factor being set.
// - Static in divide modes: a stopped reference freezes the machine clock; the PLL runs on until the period counter saturates.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dspclk_top
  import dspclk_pkg::*;
(
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_n_i,
  // Mode pins and reference
  input  wire logic                       clock_mode_pin_a_i,
  input  wire logic                       clock_mode_pin_b_i,
  input  wire logic                       clock_mode_pin_c_i,
  input  wire logic                       reference_clock_i,
  // Register port
  input  wire dspclk_pkg::dspclk_bus_s    bus_i,
  output logic [dspclk_pkg::DATA_W-1:0]   rd_data_o,
  // Clock outputs
  output logic                            machine_clk_o,
  output logic                            machine_clk_en_o,
  output logic                            clock_output_pin_o,
  output logic                            osc_enable_o,
  output logic                            pll_locked_o
);
  import dspclk_pkg::*;

  localparam int LOCK_BOUND = LOCK_CYCLES + 2;

  // ==========================================================================
  // Mode pin capture and decode
  logic [2:0]   strap_reg;
  dspclk_mode_e boot_mode;
  logic         boot_osc;

  // Captured on every reset cycle so the value at release is kept
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      strap_reg <= {clock_mode_pin_a_i, clock_mode_pin_b_i, clock_mode_pin_c_i};
    end
  end

  assign boot_mode = (strap_reg == STRAP_DIV4) ? DSPCLK_MODE_DIV4 :
                     ((strap_reg == STRAP_DIV2_LO) || (strap_reg == STRAP_DIV2_HI)) ?
                     DSPCLK_MODE_DIV2 : DSPCLK_MODE_PLL;
  // Crystal only for PLL patterns with pin c low; others take an external source
  assign boot_osc  = (boot_mode == DSPCLK_MODE_PLL) && !strap_reg[0];

  // ==========================================================================
  // Reference edge detect and period measurement
  logic                ref_d_reg;
  logic                ref_rise;
  logic [PERIOD_W-1:0] cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic                period_ok_reg;
  logic                ref_stalled;

  assign ref_rise    = reference_clock_i && !ref_d_reg;
  assign ref_stalled = &cnt_reg;

  // Counter saturates, so a stopped reference never wraps into a bogus period
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ref_d_reg     <= 1'b1;  // High, so a reference already high gives no false edge
      cnt_reg       <= '0;
      period_reg    <= '0;
      period_ok_reg <= 1'b0;
    end else begin
      ref_d_reg <= reference_clock_i;
      if (ref_rise) begin
        period_reg    <= cnt_reg + 1'b1;
        period_ok_reg <= !ref_stalled;
        cnt_reg       <= '0;
      end else if (!ref_stalled) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else begin
        period_ok_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register file
  logic [5:0] mult_reg;
  logic [5:0] mult_act_reg;
  logic       pll_en_reg;
  logic [1:0] output_clock_divide_field_reg;
  logic       wr_cmr;
  logic       wr_bank_switch_control_register;
  logic [5:0] wr_mult;
  logic       mult_legal;

  assign wr_cmr     = bus_i.wr && (bus_i.addr == CMR_OFF);
  assign wr_bank_switch_control_register    = bus_i.wr && (bus_i.addr == BANK_SWITCH_CONTROL_REGISTER_OFF);
  assign wr_mult    = bus_i.wdata[MULT_INT_LSB+3:MULT_FRAC_LSB];
  // Factor below 1.0 not supported; such a write keeps the old factor
  assign mult_legal = (wr_mult[5:2] != 4'h0);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mult_reg   <= MULT_RESET;
      pll_en_reg <= 1'b0;
      output_clock_divide_field_reg <= OUTPUT_CLOCK_DIVIDE_FIELD_RESET;
    end else begin
      if (wr_cmr) begin
        pll_en_reg <= bus_i.wdata[PLL_EN_BIT];
        if (mult_legal) begin
          mult_reg <= wr_mult;
        end
      end
      if (wr_bank_switch_control_register) begin
        output_clock_divide_field_reg <= bus_i.wdata[OUTPUT_CLOCK_DIVIDE_FIELD_LSB+1:OUTPUT_CLOCK_DIVIDE_FIELD_LSB];
      end
    end
  end

  // ==========================================================================
  // Lock timer: restarted by every accepted factor write; counts down only while the PLL is wanted
  logic                       want_pll;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_reg;
  logic                       locked;
  logic                       relock;

  assign want_pll = pll_en_reg || (boot_mode == DSPCLK_MODE_PLL);
  assign relock   = wr_cmr && mult_legal;
  assign locked   = (lock_cnt_reg == '0);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lock_cnt_reg <= '0;
    end else if (relock) begin
      lock_cnt_reg <= ($clog2(LOCK_CYCLES+1))'(LOCK_CYCLES);
    end else if (!locked && want_pll) begin
      lock_cnt_reg <= lock_cnt_reg - 1'b1;
    end
  end

  // ==========================================================================
  // Half-period sources: divider from reference edges, PLL as a phase accumulator
  logic        div4_ph_reg;
  logic        div_half;
  logic [21:0] acc_reg;
  logic [21:0] acc_sum;
  logic [21:0] acc_thr;
  logic        nco_half;
  logic        use_pll_reg;
  logic        sel_half;
  logic        mclk_reg;
  logic        switch_due;

  // Half period of machine clock is one reference period (/2) or two (/4)
  assign div_half = ref_rise && ((boot_mode != DSPCLK_MODE_DIV4) || div4_ph_reg);
  // Rate = 2*factor/period half ticks; factor held in quarters
  assign acc_sum  = acc_reg + 22'({mult_act_reg, 1'b0});
  assign acc_thr  = 22'({period_reg, 2'b00});
  assign nco_half = period_ok_reg && (acc_sum >= acc_thr);
  assign sel_half = use_pll_reg ? nco_half : div_half;
  // Change source only when the clock is about to fall: no runt high phase
  assign switch_due = locked && mclk_reg && sel_half &&
                      ((use_pll_reg != want_pll) || (mult_act_reg != mult_reg));

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      div4_ph_reg <= 1'b0;
      acc_reg     <= '0;
    end else begin
      if (ref_rise) begin
        div4_ph_reg <= !div4_ph_reg;
      end
      if (switch_due) begin
        acc_reg <= '0;
      end else if (nco_half) begin
        acc_reg <= ((acc_sum - acc_thr) >= acc_thr) ? '0 : acc_sum - acc_thr;
      end else if (period_ok_reg) begin
        acc_reg <= acc_sum;
      end
    end
  end

  // Source select and machine clock phase; PLL modes start at factor 1.0
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      use_pll_reg  <= 1'b0;
      mult_act_reg <= MULT_RESET;
      mclk_reg     <= 1'b0;
    end else begin
      if (switch_due) begin
        use_pll_reg  <= want_pll;
        mult_act_reg <= mult_reg;
      end
      if (sel_half) begin
        mclk_reg <= !mclk_reg;
      end
    end
  end

  // ==========================================================================
  // Reference period check against the limits of the active mode
  logic range_err;
  logic [PERIOD_W-1:0] ref_max;

  assign ref_max   = !use_pll_reg ? PERIOD_W'(16'hFFFF) :
                     (mult_act_reg[0]) ? PERIOD_W'(REF_MAX_Q_CYC) :
                     (mult_act_reg[1]) ? PERIOD_W'(REF_MAX_H_CYC) :
                     PERIOD_W'(REF_MAX_INT_CYC);
  assign range_err = period_ok_reg && ((period_reg < PERIOD_W'(REF_MIN_CYC)) ||
                     (period_reg > ref_max));

  // ==========================================================================
  // Read port and registered outputs
  logic [DATA_W-1:0] rd_mux;

  assign rd_mux = (bus_i.addr == CMR_OFF)  ? DATA_W'({pll_en_reg, mult_reg}) :
                  (bus_i.addr == BANK_SWITCH_CONTROL_REGISTER_OFF) ? DATA_W'(output_clock_divide_field_reg) :
                  (bus_i.addr == STAT_OFF) ? DATA_W'({strap_reg, range_err, osc_enable_o,
                                                      use_pll_reg, locked}) :
                  16'h0000;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rd_data_o        <= 16'h0000;
      machine_clk_en_o <= 1'b0;
      osc_enable_o     <= 1'b0;
      pll_locked_o     <= 1'b0;
    end else begin
      rd_data_o        <= bus_i.rd ? rd_mux : 16'h0000;
      machine_clk_en_o <= sel_half && !mclk_reg;
      osc_enable_o     <= boot_osc;
      pll_locked_o     <= use_pll_reg && locked;
    end
  end

  assign machine_clk_o = mclk_reg;

  dspclk_out_div u_out_div (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .half_tick_i (sel_half),
    .output_clock_divide_field_i    (output_clock_divide_field_reg),
    .clk_out_o   (clock_output_pin_o)
  );

  // ==========================================================================
  // Lock age check helper
  // Cycles spent waiting for lock, counted apart from the lock timer itself
  logic [12:0] unlock_age_reg;

  // Saturates, so a lock that never comes keeps the check firing
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || locked || relock) begin
      unlock_age_reg <= 13'h0000;
    end else if (want_pll && !(&unlock_age_reg)) begin
      unlock_age_reg <= unlock_age_reg + 13'h0001;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  div4_mode_a: assert property (boot_mode == DSPCLK_MODE_DIV4 && !use_pll_reg && ref_rise
      |-> sel_half == div4_ph_reg) else $error("divide-by-4 phase wrong");
  osc_off_a: assert property ((boot_mode != DSPCLK_MODE_PLL) |=> !osc_enable_o)
      else $error("oscillator on in divide mode");
  output_clock_divide_field_rst_a: assert property ($rose(reset_n_i) |-> output_clock_divide_field_reg == OUTPUT_CLOCK_DIVIDE_FIELD_RESET)
      else $error("divide field reset value wrong");
  pin_follow_a: assert property (output_clock_divide_field_reg == OUTPUT_CLOCK_DIVIDE_FIELD_NONE && sel_half && !wr_bank_switch_control_register
      |=> clock_output_pin_o != $past(clock_output_pin_o)) else $error("pin not toggling");
  lock_time_a: assert property (unlock_age_reg <= 13'(LOCK_BOUND))
      else $error("lock too slow");
  mult_zero_a: assert property (wr_cmr && wr_mult[5:2] == 4'h0 |=> $stable(mult_reg))
      else $error("illegal factor accepted");
  stall_hold_a: assert property (!use_pll_reg && !ref_rise |-> !sel_half)
      else $error("clock runs with reference stopped");
  glitch_free_a: assert property ($changed(use_pll_reg) |-> !mclk_reg && $past(locked))
      else $error("source switched at unsafe phase");
  div2_rate_a: assert property (!use_pll_reg && boot_mode == DSPCLK_MODE_DIV2
      |-> sel_half == ref_rise) else $error("divide-by-2 rate wrong");
  osc_on_a: assert property (boot_mode == DSPCLK_MODE_PLL && !strap_reg[0]
      |=> osc_enable_o) else $error("oscillator off in crystal mode");
  pll_flag_a: assert property (pll_locked_o |-> $past(locked))
      else $error("locked flag shown while locking");
  rd_idle_a: assert property (!bus_i.rd |=> rd_data_o == '0)
      else $error("read data outside read cycle");

  // Scenarios the bench is expected to reach
  switch_c:   cover property (switch_due && want_pll);
  relock_c:   cover property (unlock_age_reg == 13'(LOCK_CYCLES));
  div4_c:     cover property (boot_mode == DSPCLK_MODE_DIV4 && sel_half);
  frac_c:     cover property (use_pll_reg && mult_act_reg[0]);
  pin_full_c: cover property (output_clock_divide_field_reg == OUTPUT_CLOCK_DIVIDE_FIELD_NONE && sel_half);

endmodule
`default_nettype wire

// ---- bench/dspclk_ref_model.sv ----
// Reference clock source model standing in for the oscillator or crystal.
// Assumes the bench sets the half period in ns and may stop the source.
`timescale 1ns/1ps
`default_nettype none
module dspclk_ref_model (
  // Control from the bench
  input  wire logic        run_i,
  input  wire logic [15:0] half_ns_i,
  // Reference pin
  output logic             ref_clk_o
);
  // ==========================================================================
  // Source
  logic [15:0] half_ns;

  // Never faster than a 20 ns period, whatever the bench asks
  assign half_ns = (half_ns_i < 16'h000A) ? 16'h000A : half_ns_i;

  // Free phase against the core clock; a stopped source parks low
  initial begin
    ref_clk_o = 1'b0;
    #3;
    forever begin
      if (run_i) begin
        #(half_ns);
        ref_clk_o = ~ref_clk_o;
      end else begin
        ref_clk_o = 1'b0;
        @(posedge run_i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench: straps, output divider, stopped reference, PLL factors.
// Assumes dspclk_pkg, dspclk_top and the reference model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  import dspclk_pkg::*;
  // ==========================================================================
  // Signals
  logic              core_clk_i, reset_n_i, pa, pb, pc, run;
  logic [15:0]       half;
  logic              ref_clk, mclk, mclk_en, pin, osc, lck, ref_q, mclk_q, pin_q;
  dspclk_bus_s       bus;
  logic [DATA_W-1:0] rdat, rv;
  logic [31:0]       seed;
  int                err_count, comparisons, n_ref, n_mclk, n_pin, n_en, q;

  dspclk_ref_model u_dspclk_ref_model (.run_i(run), .half_ns_i(half), .ref_clk_o(ref_clk));
  dspclk_top u_dspclk_top (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clock_mode_pin_a_i(pa),
    .clock_mode_pin_b_i(pb), .clock_mode_pin_c_i(pc), .reference_clock_i(ref_clk),
    .bus_i(bus), .rd_data_o(rdat), .machine_clk_o(mclk), .machine_clk_en_o(mclk_en),
    .clock_output_pin_o(pin), .osc_enable_o(osc), .pll_locked_o(lck));

  // ==========================================================================
  // Clock, edge counters, helpers
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Rising edges counted on sampled levels, as the design sees them
  always @(posedge core_clk_i) begin
    ref_q <= ref_clk;
    mclk_q <= mclk;
    pin_q <= pin;
    n_ref += int'(ref_clk & !ref_q);
    n_mclk += int'(mclk & !mclk_q);
    n_pin += int'(pin & !pin_q);
    n_en += int'(mclk_en);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Divide-only straps leave the PLL and oscillator off
  function automatic logic div_pat(input logic [2:0] p);
    return (p == STRAP_DIV2_LO) || (p == STRAP_DIV4) || (p == STRAP_DIV2_HI);
  endfunction

  // Window edges may cut a period, so allow a small slack
  function automatic logic near(input int got, input int exp);
    return (got >= exp - 2) && (got <= exp + 2);
  endfunction

  // ==========================================================================
  // Bus and sequencing tasks
  task automatic do_reset(input logic [2:0] p);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    {pa, pb, pc} <= p;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_i);
    bus <= '0;
    #1 rv = rdat;
  endtask

  task automatic meas(input int cyc);
    @(negedge core_clk_i);
    {n_ref, n_mclk, n_pin, n_en} = '0;
    repeat (cyc) @(negedge core_clk_i);
  endtask

  task automatic close_out;
    $display("tb: %0d compares, %0d errors", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well past the roughly 600 us the tests need
  initial begin
    #1ms;
    err_count++;
    close_out;
  end

  // ==========================================================================
  // Tests
  initial begin
    {reset_n_i, pa, pb, pc} = 4'h0;
    bus = '0;
    run = 1'b1;
    half = 16'h0032;
    seed = 32'h0000_0061;
    err_count = 0;
    comparisons = 0;
    // Every strap pattern: mode, oscillator, reset values; rates for divide straps
    for (int p = 0; p < 8; p++) begin
      do_reset(3'(p));
      // PLL straps hand over to the multiplied source within two reference periods
      repeat (50) @(posedge core_clk_i);
      rd(STAT_OFF);
      `CHK(rv[6:4], 3'(p))
      `CHK(rv[ST_PLL_BIT], !div_pat(3'(p)))
      `CHK(osc, !div_pat(3'(p)) && !p[0])
      `CHK(rv[ST_OSC_BIT], !div_pat(3'(p)) && !p[0])
      rd(BANK_SWITCH_CONTROL_REGISTER_OFF);
      `CHK(rv[1:0], OUTPUT_CLOCK_DIVIDE_FIELD_RESET)
      rd(CMR_OFF);
      `CHK(rv, {10'h000, MULT_RESET})
      if (div_pat(3'(p))) begin
        meas(2000);
        `CHK(near(n_mclk, (3'(p) == STRAP_DIV4) ? n_ref / 4 : n_ref / 2), 1'b1)
        `CHK(near(n_pin, n_mclk / 4), 1'b1)
        `CHK(near(n_en, n_mclk), 1'b1)
      end
      $display("tb: strap %0d done", p);
    end
    // Output divider codes, undivided first, then random
    do_reset(STRAP_DIV2_LO);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      q = (i == 0) ? 0 : int'(seed[1:0]);
      wr(BANK_SWITCH_CONTROL_REGISTER_OFF, 16'(q));
      rd(BANK_SWITCH_CONTROL_REGISTER_OFF);
      `CHK(rv[1:0], 2'(q))
      meas(2000);
      `CHK(near(n_pin, n_mclk / (q + 1)), 1'b1)
    end
    // Unmapped places read zero; status ignores writes
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(4'(3 + seed[3:0] % 13), seed[31:16]);
      rd(4'(3 + seed[3:0] % 13));
      `CHK(rv, 16'h0000)
    end
    wr(STAT_OFF, 16'hFFFF);
    rd(STAT_OFF);
    `CHK(rv[6:1], 6'h00)
    $display("tb: divider and map done");
    // Stopped reference freezes the machine clock, then it carries on
    @(posedge core_clk_i) run <= 1'b0;
    // A half period already under way may still finish with a rising edge
    repeat (20) @(posedge core_clk_i);
    meas(3000);
    `CHK(n_mclk, 0)
    @(posedge core_clk_i) run <= 1'b1;
    meas(2000);
    `CHK(near(n_mclk, n_ref / 2), 1'b1)
    $display("tb: static stop done");
    // First factor: old divide clock must run on while locking
    wr(CMR_OFF, 16'h0048);
    meas(1000);
    `CHK(lck, 1'b0)
    `CHK(near(n_mclk, n_ref / 2), 1'b1)
    repeat (2100) @(negedge core_clk_i);
    `CHK(lck, 1'b1)
    // Integer and half factors, fixed then random
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      q = (i < 3) ? 4 + 2 * i : 4 + 2 * int'(seed[0]) + 2 * int'(seed[1]);
      wr(CMR_OFF, 16'h0040 | 16'(q));
      repeat (3100) @(negedge core_clk_i);
      `CHK(lck, 1'b1)
      meas(2000);
      `CHK(near(n_mclk, n_ref * q / 4), 1'b1)
      rd(STAT_OFF);
      `CHK(rv[ST_RANGE_BIT], 1'b0)
    end
    // Quarter factor with a 100 ns reference is out of range
    wr(CMR_OFF, 16'h0045);
    repeat (3100) @(negedge core_clk_i);
    rd(STAT_OFF);
    `CHK(rv[ST_RANGE_BIT], 1'b1)
    // Integer part zero is refused, old factor kept
    wr(CMR_OFF, 16'h0042);
    rd(CMR_OFF);
    `CHK(rv[5:0], 6'h05)
    $display("tb: pll factors done");
    close_out;
  end
endmodule
`default_nettype wire
